// File: hw/adc_conv_pkg.sv
// ----------------------------------------------------------------------------
// constants shared by the converter interface logic
// ----------------------------------------------------------------------------
// assumes a 100 MHz system clock that also serves as the converter master clock
// source; all counts below are in system clock cycles or master clock edges
package adc_conv_pkg;

   // ----------------------------------------------------------------------------
   // widths and word layout
   // ----------------------------------------------------------------------------
   localparam int RESULT_W = 14;
   localparam int SER_W = 16;
   localparam int LEAD_ZEROS = 2;
   localparam int LO_BYTE_W = 8;
   localparam int HI_BYTE_W = 6;
   localparam int SYNC_STAGES = 3;
   localparam int BIT_CNT_W = 5;

   // ----------------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int LATE_START_NS = 30;
   // longest time: rounds down
   localparam int LATE_START_CYC = (LATE_START_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   LATE_START_NS / CLK_PERIOD_NS;
   localparam int CONV_RISES_SHORT = 19;
   localparam int CONV_RISES_LONG = 20;
   localparam int MCLK_DIV_DEFAULT = 8;

   // ----------------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------------
   localparam logic BUSY_N_RESET = 1'b1;
   localparam logic SCLK_RESET = 1'b0;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 14'h0000;

   // ----------------------------------------------------------------------------
   // conversion states
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      CONV_IDLE = 2'b01,
      CONV_BUSY = 2'b10
   } conv_state_t;

endpackage

// File: hw/ser_link_if.sv
// ----------------------------------------------------------------------------
// carrier between the conversion control and the serial word shifter
// ----------------------------------------------------------------------------
// assumes both ends run on the system clock with the same clock enable
`timescale 1ns/1ps
interface ser_link_if;
   logic mclk_rise;
   logic mclk_fall;
   logic load;
   logic [adc_conv_pkg::RESULT_W-1:0] word;
   logic ser_data_out;
   logic sending;

   modport ctrl (
      output mclk_rise,
      output mclk_fall,
      output load,
      output word,
      input ser_data_out,
      input sending
   );
   modport shifter (
      input mclk_rise,
      input mclk_fall,
      input load,
      input word,
      output ser_data_out,
      output sending
   );
endinterface

// File: hw/pin_sync.sv
// ----------------------------------------------------------------------------
// three-stage input synchroniser with agreement filter
// ----------------------------------------------------------------------------
// assumes inputs are asynchronous pins; a change is accepted once the second
// and third stages agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // pins
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   if (W < 1) begin : g_bad_w
      $error("pin_sync: W must be at least 1");
   end

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic s1_r, s2_r, s3_r, out_r, out_nxt;
         always_comb begin
            out_nxt = (s2_r == s3_r) ? s3_r : out_r;
         end
         // s1_r feeds s2_r only
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               s1_r <= INIT[g];
               s2_r <= INIT[g];
               s3_r <= INIT[g];
               out_r <= INIT[g];
            end else if (ce_i) begin
               s1_r <= async_i[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               out_r <= out_nxt;
            end
         end
         assign sync_o[g] = out_r;
      end
   endgenerate
endmodule // pin_sync

// File: hw/ser_word_shifter.sv
// ----------------------------------------------------------------------------
// serial result shifter: two leading zeros then the result, msb first
// ----------------------------------------------------------------------------
// assumes master clock edge pulses from the control block, one cycle each
`timescale 1ns/1ps
module ser_word_shifter (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // link to control
   ser_link_if.shifter link
);
   logic [adc_conv_pkg::SER_W-1:0] shreg_r, shreg_nxt;
   logic [adc_conv_pkg::BIT_CNT_W-1:0] falls_r, falls_nxt;
   logic sending_r, sending_nxt;

   always_comb begin
      shreg_nxt = shreg_r;
      falls_nxt = falls_r;
      sending_nxt = sending_r;
      if (link.load) begin
         shreg_nxt = {{adc_conv_pkg::LEAD_ZEROS{1'b0}}, link.word};
         falls_nxt = '0;
         sending_nxt = 1'b1;
      end else if (sending_r) begin
         if (link.mclk_fall) begin
            falls_nxt = falls_r + 1'b1;
            if (falls_r == 5'(adc_conv_pkg::SER_W - 1)) begin
               sending_nxt = 1'b0;
            end
         end
         if (link.mclk_rise && falls_r != '0) begin
            shreg_nxt = {shreg_r[adc_conv_pkg::SER_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shreg_r <= '0;
         falls_r <= '0;
         sending_r <= 1'b0;
      end else if (ce_i) begin
         shreg_r <= shreg_nxt;
         falls_r <= falls_nxt;
         sending_r <= sending_nxt;
      end
   end

   assign link.ser_data_out = shreg_r[adc_conv_pkg::SER_W-1];
   assign link.sending = sending_r;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   a_data_on_rise: assert property (
      (sending_r && !$past(link.load) && $changed(shreg_r[adc_conv_pkg::SER_W-1]))
      |-> $past(link.mclk_rise))
      else $error("serial data changed away from a rising edge");
   a_lead_zero: assert property (
      (ce_i && link.load) |=> (shreg_r[adc_conv_pkg::SER_W-1:adc_conv_pkg::SER_W-2] == 2'b00))
      else $error("serial word lacks two leading zeros");
endmodule // ser_word_shifter

// File: hw/adc_host_conversion_interface.sv
// ----------------------------------------------------------------------------
// converter digital interface: start, busy, parallel/byte read, serial output
// ----------------------------------------------------------------------------
// assumes control pins are asynchronous and the sample input is stable on the
// system clock; the master clock is the system clock divided by MCLK_DIV
`timescale 1ns/1ps
module adc_host_conversion_interface #(
   parameter int MCLK_DIV = adc_conv_pkg::MCLK_DIV_DEFAULT
) (
   // clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // host control pins
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic timer_start_n_i,
   input wire logic high_byte_select_i,
   // configuration pins
   input wire logic fmt_parallel14_i,
   input wire logic sclk_continuous_i,
   // sample from the analog front end
   input wire logic [adc_conv_pkg::RESULT_W-1:0] sample_i,
   // status and hold
   output logic busy_n_o,
   output logic hold_o,
   // parallel data
   output logic [adc_conv_pkg::RESULT_W-1:0] db_o,
   output logic db_oe_o,
   // serial pins
   output logic ser_clk_o,
   output logic ser_clk_oe_o,
   output logic ser_data_out_o,
   output logic ser_data_out_oe_o,
   output logic ser_frame_n_o,
   output logic ser_frame_n_oe_o
);
   localparam int DIV_W = $clog2(MCLK_DIV);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MCLK_DIV - 1);
   localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(MCLK_DIV / 2 - 1);
   localparam logic [DIV_W-1:0] LATE_CYC = DIV_W'(adc_conv_pkg::LATE_START_CYC);

   if (MCLK_DIV < 4 || (MCLK_DIV % 2) != 0) begin : g_bad_div
      $error("MCLK_DIV must be even and >= 4");
   end
   if (MCLK_DIV <= adc_conv_pkg::LATE_START_CYC) begin : g_bad_late
      $error("MCLK_DIV too small for late window");
   end

   // ----------------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------------
   logic [5:0] pins_s;
   logic cs_s, rd_s, ts_s, hbs_s, fmt14_s, cont_s;

   pin_sync #(.W(6), .INIT(6'h0F)) u_pin_sync (
      .clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .async_i({fmt_parallel14_i, sclk_continuous_i, high_byte_select_i,
                timer_start_n_i, rd_n_i, cs_n_i}),
      .sync_o(pins_s)
   );
   assign cs_s = pins_s[0];
   assign rd_s = pins_s[1];
   assign ts_s = pins_s[2];
   assign hbs_s = pins_s[3];
   assign cont_s = pins_s[4];
   assign fmt14_s = pins_s[5];

   // ----------------------------------------------------------------------------
   // master clock divider, also the serial clock
   // ----------------------------------------------------------------------------
   logic [DIV_W-1:0] div_r, div_nxt;
   logic sclk_r, sclk_nxt;
   logic mclk_rise, mclk_fall;

   assign mclk_rise = (div_r == DIV_LAST);
   assign mclk_fall = (div_r == DIV_HALF);

   always_comb begin
      div_nxt = mclk_rise ? '0 : div_r + 1'b1;
      sclk_nxt = sclk_r;
      if (mclk_rise) begin
         sclk_nxt = 1'b1;
      end else if (mclk_fall) begin
         sclk_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_r <= '0;
         sclk_r <= adc_conv_pkg::SCLK_RESET;
      end else if (ce_i) begin
         div_r <= div_nxt;
         sclk_r <= sclk_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // conversion control
   // ----------------------------------------------------------------------------
   adc_conv_pkg::conv_state_t state_r, state_nxt;
   logic [adc_conv_pkg::BIT_CNT_W-1:0] rises_left_r, rises_left_nxt;
   logic [adc_conv_pkg::RESULT_W-1:0] result_r, result_nxt;
   logic cs_prev_r, ts_prev_r, rdact_prev_r;
   logic proc_mode_r, proc_mode_nxt;
   logic int_r, int_nxt;
   logic converting, start_proc, start_timer, start, read_act, read_edge, conv_done;
   logic late_start;

   assign converting = (state_r == adc_conv_pkg::CONV_BUSY);
   assign read_act = !cs_s && !rd_s;
   assign read_edge = read_act && !rdact_prev_r;
   assign start_proc = !converting && !ts_s && cs_prev_r && !cs_s && !hbs_s;
   // timer start edge, same serial path
   assign start_timer = !converting && ts_s && !ts_prev_r;
   assign start = start_proc || start_timer;
   assign conv_done = converting && mclk_rise && rises_left_r == 5'd1;
   // late start adds a rising edge
   assign late_start = (DIV_LAST - div_r) < LATE_CYC;

   always_comb begin
      state_nxt = state_r;
      rises_left_nxt = rises_left_r;
      result_nxt = result_r;
      proc_mode_nxt = proc_mode_r;
      int_nxt = int_r;
      unique case (state_r)
         adc_conv_pkg::CONV_IDLE: begin
            if (start) begin
               state_nxt = adc_conv_pkg::CONV_BUSY;
               result_nxt = sample_i;
               proc_mode_nxt = start_proc;
               rises_left_nxt = late_start ? 5'(adc_conv_pkg::CONV_RISES_LONG) :
                                             5'(adc_conv_pkg::CONV_RISES_SHORT);
            end
         end
         adc_conv_pkg::CONV_BUSY: begin
            if (mclk_rise) begin
               rises_left_nxt = rises_left_r - 1'b1;
            end
            if (conv_done) begin
               state_nxt = adc_conv_pkg::CONV_IDLE;
            end
         end
         default: begin
            state_nxt = adc_conv_pkg::CONV_IDLE;
         end
      endcase
      // timer mode end flag: a new end beats a read clear in the same cycle
      if (read_edge) begin
         int_nxt = 1'b0;
      end
      if (conv_done && !proc_mode_r) begin
         int_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= adc_conv_pkg::CONV_IDLE;
         rises_left_r <= '0;
         result_r <= adc_conv_pkg::RESULT_RESET;
         proc_mode_r <= 1'b1;
         int_r <= 1'b0;
         cs_prev_r <= 1'b1;
         ts_prev_r <= 1'b1;
         rdact_prev_r <= 1'b0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         rises_left_r <= rises_left_nxt;
         result_r <= result_nxt;
         proc_mode_r <= proc_mode_nxt;
         int_r <= int_nxt;
         cs_prev_r <= cs_s;
         ts_prev_r <= ts_s;
         rdact_prev_r <= read_act;
      end
   end

   assign busy_n_o = proc_mode_r ? !converting : !int_r;
   assign hold_o = converting;

   // ----------------------------------------------------------------------------
   // parallel and byte read path
   // ----------------------------------------------------------------------------
   logic [adc_conv_pkg::RESULT_W-1:0] db_r, db_nxt;

   always_comb begin
      if (fmt14_s) begin
         db_nxt = result_r;
      end else if (hbs_s) begin
         db_nxt = {{(adc_conv_pkg::RESULT_W - adc_conv_pkg::HI_BYTE_W){1'b0}},
                   result_r[adc_conv_pkg::RESULT_W-1:adc_conv_pkg::LO_BYTE_W]};
      end else begin
         db_nxt = {{(adc_conv_pkg::RESULT_W - adc_conv_pkg::LO_BYTE_W){1'b0}},
                   result_r[adc_conv_pkg::LO_BYTE_W-1:0]};
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         db_r <= '0;
      end else if (ce_i) begin
         db_r <= db_nxt;
      end
   end

   assign db_o = db_r;
   // drive only during read; a read held over busy sees the new result
   assign db_oe_o = read_act;

   // ----------------------------------------------------------------------------
   // serial output
   // ----------------------------------------------------------------------------
   ser_link_if link ();
   logic serial_en;

   assign link.mclk_rise = mclk_rise;
   assign link.mclk_fall = mclk_fall;
   assign link.load = start;
   assign link.word = sample_i;

   ser_word_shifter u_shifter (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .link(link)
   );

   assign serial_en = !fmt14_s;
   assign ser_clk_oe_o = serial_en && (cont_s || converting);
   assign ser_clk_o = sclk_r;
   assign ser_data_out_o = link.ser_data_out;
   assign ser_data_out_oe_o = serial_en && converting;
   assign ser_frame_n_o = !link.sending;
   assign ser_frame_n_oe_o = serial_en;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   logic [adc_conv_pkg::BIT_CNT_W-1:0] rise_seen_r;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rise_seen_r <= '0;
      end else if (ce_i) begin
         if (start) begin
            rise_seen_r <= '0;
         end else if (converting && mclk_rise) begin
            rise_seen_r <= rise_seen_r + 1'b1;
         end
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   a_start_hold: assert property (
      (ce_i && start_proc) |=> (hold_o && !busy_n_o))
      else $error("chip select start did not enter hold");
   a_busy_conv: assert property (
      (proc_mode_r && converting) |-> !busy_n_o)
      else $error("busy high during processor-mode conversion");
   a_busy_rest: assert property (
      (!converting && !int_r) |-> busy_n_o)
      else $error("busy low while idle");
   a_conv_len: assert property (
      $fell(converting) |-> (rise_seen_r == 5'd19 || rise_seen_r == 5'd20))
      else $error("conversion length not 19 or 20 rising edges");
   a_db_float: assert property (
      (cs_s || rd_s) |-> !db_oe_o)
      else $error("data driven outside a read");
   a_high_byte: assert property (
      (ce_i && !fmt14_s && hbs_s) |=> (db_r == {8'h00, $past(result_r[13:8])}))
      else $error("high byte not right-justified");
   a_gated_float: assert property (
      (!cont_s && !converting) |-> (!ser_clk_oe_o && !ser_data_out_oe_o))
      else $error("gated serial lines driven while idle");
   a_cont_clock: assert property (
      (serial_en && cont_s) |-> ser_clk_oe_o)
      else $error("continuous serial clock stopped");
   a_frame_start: assert property (
      (ce_i && start) |=> (!ser_frame_n_o && ser_data_out_o == 1'b0))
      else $error("strobe or first bit wrong at start");
endmodule // adc_host_conversion_interface

// File: test/ser_receiver_model.sv
// ----------------------------------------------------------------------------
// serial receiver model: oversamples the open-drain serial pins on its own clock
// ----------------------------------------------------------------------------
// assumes pull-ups are resolved by the bench and the link clock is well above
// twice the serial clock rate
`timescale 1ns/1ps
module ser_receiver_model (
   // link clock
   input wire logic link_clk_i,
   // serial pins as seen on the wire
   input wire logic ser_clk_i,
   input wire logic ser_data_out_i,
   input wire logic ser_frame_n_i,
   // captured words
   output logic [15:0] word_o,
   output logic [7:0] count_o
);
   logic [2:0] clk_s;
   logic [1:0] dat_s;
   logic [2:0] frm_s;
   logic [15:0] shift_r;
   logic [4:0] nbits_r;

   initial begin
      clk_s = 3'h0;
      dat_s = 2'h0;
      frm_s = 3'h7;
      shift_r = 16'h0000;
      nbits_r = 5'h00;
      word_o = 16'h0000;
      count_o = 8'h00;
   end

   // clock and data share one sampling path so their relative timing is kept
   always @(posedge link_clk_i) begin
      clk_s <= {clk_s[1:0], ser_clk_i};
      dat_s <= {dat_s[0], ser_data_out_i};
      frm_s <= {frm_s[1:0], ser_frame_n_i};
      // strobe level just before a fall marks a valid bit
      if (frm_s[2]) begin
         nbits_r <= 5'h00;
      end else if (clk_s[2] && !clk_s[1]) begin
         shift_r <= {shift_r[14:0], dat_s[1]};
         nbits_r <= nbits_r + 5'h01;
         if (nbits_r == 5'h0F) begin
            word_o <= {shift_r[14:0], dat_s[1]};
            count_o <= count_o + 8'h01;
            nbits_r <= 5'h00;
         end
      end
   end
endmodule // ser_receiver_model

// File: test/adc_host_conversion_interface_tb_top.sv
// ----------------------------------------------------------------------------
// testbench for the converter interface: processor, byte and timer conversions
// ----------------------------------------------------------------------------
// holds the design's clock-enable high except during the frozen-design check; pins change at
// rising edges and reach the design through its own synchronisers
`timescale 1ns/1ps
module adc_host_conversion_interface_tb_top;
   localparam int DIV = 8;
   logic sys_clk_i = 1'b0;
   logic link_clk = 1'b0;
   logic resetn_i = 1'b0;
   logic ce = 1'b1;
   logic cs_n = 1'b1;
   logic rd_n = 1'b1;
   logic tstart_n = 1'b0;
   logic hbs = 1'b0;
   logic fmt14 = 1'b0;
   logic cont = 1'b0;
   logic [13:0] sample = 14'h0000;
   logic busy_n_o, hold_o, db_oe_o, sclk, sclk_oe, sdat, sdat_oe, frm_n, frm_oe;
   logic [13:0] db_o;
   logic [15:0] rx_word;
   logic [7:0] rx_count;
   int n_errors = 0;
   int n_tests = 0;

   always #5 sys_clk_i = ~sys_clk_i;
   always #7.5 link_clk = ~link_clk;

   adc_host_conversion_interface #(.MCLK_DIV(DIV)) dut (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce),
      .cs_n_i(cs_n), .rd_n_i(rd_n), .timer_start_n_i(tstart_n),
      .high_byte_select_i(hbs), .fmt_parallel14_i(fmt14), .sclk_continuous_i(cont),
      .sample_i(sample), .busy_n_o(busy_n_o), .hold_o(hold_o), .db_o(db_o),
      .db_oe_o(db_oe_o), .ser_clk_o(sclk), .ser_clk_oe_o(sclk_oe),
      .ser_data_out_o(sdat), .ser_data_out_oe_o(sdat_oe),
      .ser_frame_n_o(frm_n), .ser_frame_n_oe_o(frm_oe)
   );

   // open-drain lines with pull-ups
   ser_receiver_model rx (
      .link_clk_i(link_clk), .ser_clk_i(sclk_oe ? sclk : 1'b1),
      .ser_data_out_i(sdat_oe ? sdat : 1'b1), .ser_frame_n_i(frm_oe ? frm_n : 1'b1),
      .word_o(rx_word), .count_o(rx_count)
   );

   task automatic results();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic wait_hold(input logic lvl, output int k);
      k = 0;
      while (hold_o !== lvl && k < 400) begin
         @(posedge sys_clk_i);
         k++;
      end
      if (k >= 400) check(16'h0BAD, 16'h0000);
   endtask

   // expected parallel word for the selected format and byte
   function automatic logic [15:0] exp_db(input logic f14, input logic hb, input logic [13:0] s);
      if (f14) return {2'b00, s};
      if (hb) return {10'h000, s[13:8]};
      return {8'h00, s[7:0]};
   endfunction

   // mode 0: processor 14-bit, 1: processor byte, 2: timer start, byte read
   task automatic conv(input int mode);
      logic [13:0] smp;
      logic [7:0] cnt0;
      logic hb;
      int len;
      smp = 14'($urandom_range(0, 16383));
      hb = 1'($urandom_range(0, 1));
      @(posedge sys_clk_i);
      sample <= smp;
      fmt14 <= (mode == 0);
      cont <= 1'($urandom_range(0, 1));
      tstart_n <= 1'b0;
      hbs <= 1'b0;
      tick(8);
      cnt0 = rx_count;
      tstart_n <= (mode == 2);
      cs_n <= (mode == 2);
      rd_n <= (mode == 2);
      wait_hold(1'b1, len);
      check(busy_n_o, mode == 2);
      if (mode != 0) check(frm_n, 16'h0000);
      wait_hold(1'b0, len);
      check(len >= 18 * DIV && len <= 20 * DIV + 1, 16'h0001);
      tick(3);
      if (mode == 2) begin
         check(busy_n_o, 16'h0000);
         // read only after the end flag
         hbs <= hb;
         cs_n <= 1'b0;
         rd_n <= 1'b0;
         tick(7);
      end
      check(busy_n_o, 16'h0001);
      check(db_oe_o, 16'h0001);
      check(db_o, exp_db(mode == 0, mode == 2 && hb, smp));
      if (mode == 1) begin
         cs_n <= 1'b1;
         rd_n <= 1'b1;
         tick(7);
         check(db_oe_o, 16'h0000);
         hbs <= 1'b1;
         cs_n <= 1'b0;
         rd_n <= 1'b0;
         tick(7);
         check(db_o, exp_db(1'b0, 1'b1, smp));
         check(hold_o, 16'h0000);
      end
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      tick(12);
      check(db_oe_o, 16'h0000);
      check(frm_oe, mode != 0);
      if (mode != 0) begin
         check(rx_word, {2'b00, smp});
         check(rx_count, cnt0 + 8'h01);
         check(sclk_oe, cont);
         check(sdat_oe, 16'h0000);
      end
   endtask

   // standalone use: busy drives read, an outside latch takes data on rising busy
   task automatic standalone();
      logic [13:0] smp;
      logic [13:0] latch;
      logic seen;
      logic bprev;
      smp = 14'($urandom_range(0, 16383));
      latch = 14'h0000;
      seen = 1'b0;
      bprev = 1'b1;
      @(posedge sys_clk_i);
      sample <= smp;
      fmt14 <= 1'b1;
      tstart_n <= 1'b0;
      hbs <= 1'b0;
      tick(8);
      // chip select pulse outlasts the conversion
      cs_n <= 1'b0;
      repeat (200) begin
         @(posedge sys_clk_i);
         rd_n <= busy_n_o;
         if (busy_n_o && !bprev) begin
            latch = db_o;
            seen = 1'b1;
         end
         bprev = busy_n_o;
      end
      tick(1);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      tick(8);
      check(seen, 16'h0001);
      check(latch, smp);
   endtask

   initial begin
      void'($urandom(32'hD4D7));
      tick(6);
      resetn_i <= 1'b1;
      tick(6);
      check(busy_n_o, 16'h0001);
      check(hold_o, 16'h0000);
      // frozen design ignores a chip select pulse
      ce <= 1'b0;
      cs_n <= 1'b0;
      tick(8);
      cs_n <= 1'b1;
      tick(2);
      ce <= 1'b1;
      tick(12);
      check(hold_o, 16'h0000);
      for (int i = 0; i < 12; i++) begin
         conv(i % 3);
      end
      standalone();
      results();
   end

   // watchdog: twelve conversions need well under 10000 cycles
   initial begin
      #200000;
      n_errors++;
      results();
   end
endmodule // adc_host_conversion_interface_tb_top
